/* File: inc/sbp_cfg.svh */
// constants for the synchronous burst pseudo-static RAM port
`ifndef SBP_CFG_SVH
`define SBP_CFG_SVH
// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define SBP_OFF_BCR 8'h00
`define SBP_OFF_RCR 8'h04
`define SBP_OFF_STAT 8'h08
`define SBP_OFF_CTRL 8'h0c
`define SBP_OFF_IDENT 8'h10
// ----------------------------------------------------------------
// bus_cfg_reg fields
// ----------------------------------------------------------------
`define SBP_BCR_OPMODE 15
`define SBP_BCR_LTYPE 14
`define SBP_BCR_LAT_HI 13
`define SBP_BCR_LAT_LO 11
`define SBP_BCR_WAITT 8
`define SBP_BCR_LEN_HI 2
`define SBP_BCR_LEN_LO 0
// ----------------------------------------------------------------
// reset values; ident value is arbitrary
// ----------------------------------------------------------------
`define SBP_BCR_RST 16'h9907
`define SBP_RCR_RST 16'h0010
`define SBP_IDENT_VAL 16'h5a31
// ----------------------------------------------------------------
// latency and burst length encodings
// ----------------------------------------------------------------
`define SBP_LAT_DEF 4'h4
`define SBP_LEN_4 3'h1
`define SBP_LEN_8 3'h2
`define SBP_LEN_16 3'h3
`define SBP_LEN_32 3'h4
// ----------------------------------------------------------------
// config select codes on address bits 19:18
// ----------------------------------------------------------------
`define SBP_SEL_RCR 2'h0
`define SBP_SEL_BCR 2'h2
// ----------------------------------------------------------------
// array size
// ----------------------------------------------------------------
`define SBP_MEM_AW 10
`define SBP_MEM_WORDS 1024
`endif

/* File: inc/sbp_pkg.sv */
// types for the synchronous burst pseudo-static RAM port
package sbp_pkg;
  typedef enum logic [1:0] {SBP_IDLE, SBP_LAT, SBP_XFER} sbp_state_type;
endpackage

/* File: core/sbp_port.sv */
// device side of the synchronous burst pseudo-static RAM port
`timescale 1ns/1ps
`include "sbp_cfg.svh"

module sbp_port (
  // system
  input wire logic clk,
  input wire logic sys_rst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // memory pins from the host
  input wire logic clk_in,
  input wire logic chip_en_n,
  input wire logic addr_latch_n,
  input wire logic out_en_n,
  input wire logic write_en_n,
  input wire logic lower_byte_en_n,
  input wire logic upper_byte_en_n,
  input wire logic config_reg_sel,
  input wire logic [22:0] mem_addr,
  input wire logic [15:0] dq_i,
  // memory pins to the host
  output logic [15:0] dq_o,
  output logic dq_oe,
  output logic mem_wait
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [7:0] ctl_s1_q, ctl_s2_q, ctl_p_q;
  logic [22:0] adr_s1_q, adr_s2_q, adr_p_q;
  logic [15:0] dq_s1_q, dq_s2_q, dq_p_q;

  always_ff @(posedge clk) begin
    ctl_s1_q <= {config_reg_sel, upper_byte_en_n, lower_byte_en_n, write_en_n,
                 out_en_n, addr_latch_n, chip_en_n, clk_in};
    adr_s1_q <= mem_addr;
    dq_s1_q <= dq_i;
    ctl_s2_q <= ctl_s1_q;
    adr_s2_q <= adr_s1_q;
    dq_s2_q <= dq_s1_q;
    ctl_p_q <= ctl_s2_q;
    adr_p_q <= adr_s2_q;
    dq_p_q <= dq_s2_q;
  end

  wire k_lvl = ctl_s2_q[0];
  wire ce_n = ctl_s2_q[1];
  wire adv_n = ctl_s2_q[2];
  wire oe_n = ctl_s2_q[3];
  wire we_n = ctl_s2_q[4];
  wire cfg_sel = ctl_s2_q[7];
  wire kedge = k_lvl & ~ctl_p_q[0];

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  sbp_pkg::sbp_state_type state_q;
  logic [15:0] bcr_q, rcr_q;
  logic full_sync_q, ref_req_q, rd_q, cfg_rd_q;
  logic [22:0] baddr_q;
  logic [2:0] lat_cnt_q;
  logic [3:0] lat_used_q;
  logic [5:0] word_cnt_q;
  logic [15:0] mem [0:`SBP_MEM_WORDS-1];

  // ----------------------------------------------------------------
  // configuration decode
  // ----------------------------------------------------------------
  wire sync_sel = ~bcr_q[`SBP_BCR_OPMODE];
  wire lat_fixed = bcr_q[`SBP_BCR_LTYPE];
  wire wait_early = bcr_q[`SBP_BCR_WAITT];
  wire [2:0] lat_code = bcr_q[`SBP_BCR_LAT_HI:`SBP_BCR_LAT_LO];
  wire [2:0] len_code = bcr_q[`SBP_BCR_LEN_HI:`SBP_BCR_LEN_LO];
  wire [3:0] lat_plus = {1'b0, lat_code} + 4'h1;
  wire lat_fix_ok = (lat_code >= 3'h2) && (lat_code <= 3'h6);
  wire lat_var_ok = (lat_code == 3'h2) || (lat_code == 3'h3);
  wire [3:0] lat_fix = lat_fix_ok ? lat_plus : `SBP_LAT_DEF;
  wire [3:0] lat_var = lat_var_ok ? lat_plus : `SBP_LAT_DEF;
  wire [3:0] lat_coll = 4'((lat_var << 1) - 4'h1);
  wire cont_burst = ~((len_code >= `SBP_LEN_4) && (len_code <= `SBP_LEN_32));
  wire [5:0] len_words = 6'(6'h2 << len_code);

  // ----------------------------------------------------------------
  // burst start and config access decode
  // ----------------------------------------------------------------
  wire idle = (state_q == sbp_pkg::SBP_IDLE);
  wire in_xfer = (state_q == sbp_pkg::SBP_XFER);
  wire in_lat = (state_q == sbp_pkg::SBP_LAT);
  wire latch_ev = kedge & ~ce_n & ~adv_n & sync_sel;
  wire may_restart = in_xfer & rd_q & (word_cnt_q != 6'h0);
  wire cfg_prog = latch_ev & cfg_sel & ~we_n & idle;
  wire start = latch_ev & ~cfg_prog & (idle | may_restart);
  wire ref_now = ref_req_q;
  wire [3:0] lat_sel = ~we_n ? lat_fix :
                       lat_fixed ? lat_fix :
                       ref_now ? lat_coll : lat_var;
  wire last_word = ~cont_burst & (word_cnt_q == 6'(len_words - 6'h1)) | cfg_rd_q;
  wire xfer_step = in_xfer & kedge & ~ce_n;
  wire abort_ce = ce_n & ~idle;

  // split mode asynchronous write, committed on first enable release
  wire wr_act = ~ctl_s2_q[1] & ~ctl_s2_q[4] & ~ctl_s2_q[5] & ~ctl_s2_q[6];
  wire wr_prev = ~ctl_p_q[1] & ~ctl_p_q[4] & ~ctl_p_q[5] & ~ctl_p_q[6];
  wire async_wr = wr_prev & ~wr_act & ~full_sync_q & idle;
  wire async_cfg = async_wr & ctl_p_q[7];
  wire [1:0] pin_sel = cfg_prog ? adr_s2_q[19:18] : adr_p_q[19:18];
  wire [15:0] pin_val = cfg_prog ? adr_s2_q[15:0] : adr_p_q[15:0];
  wire pin_prog = cfg_prog | async_cfg;
  wire [15:0] cfg_rdval = baddr_q[18] ? `SBP_IDENT_VAL :
                          baddr_q[19] ? bcr_q : rcr_q;

  // ----------------------------------------------------------------
  // wishbone decode
  // ----------------------------------------------------------------
  wire wb_req = wb_cyc_i & wb_stb_i;
  wire wb_wr = wb_req & wb_we_i & wb_ack_o;
  wire hit_bcr = (wb_adr_i == `SBP_OFF_BCR);
  wire hit_rcr = (wb_adr_i == `SBP_OFF_RCR);
  wire hit_ctrl = (wb_adr_i == `SBP_OFF_CTRL);
  wire [15:0] lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [15:0] wb_bcr_val = (bcr_q & ~lane_mask) | (wb_dat_i[15:0] & lane_mask);
  wire [15:0] wb_rcr_val = (rcr_q & ~lane_mask) | (wb_dat_i[15:0] & lane_mask);
  wire [31:0] stat_val = {25'h0, cfg_rd_q, rd_q, in_xfer, in_lat, ref_req_q,
                          sync_sel, full_sync_q};
  wire [31:0] rd_mux = hit_bcr ? {16'h0, bcr_q} :
                       hit_rcr ? {16'h0, rcr_q} :
                       (wb_adr_i == `SBP_OFF_STAT) ? stat_val :
                       hit_ctrl ? {31'h0, ref_req_q} :
                       (wb_adr_i == `SBP_OFF_IDENT) ? {16'h0, `SBP_IDENT_VAL} :
                       32'h0;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_req & ~wb_ack_o;
      wb_dat_o <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bcr_q <= `SBP_BCR_RST;
      rcr_q <= `SBP_RCR_RST;
    end else if (pin_prog) begin
      if (pin_sel == `SBP_SEL_BCR) bcr_q <= pin_val;
      if (pin_sel == `SBP_SEL_RCR) rcr_q <= pin_val;
    end else if (wb_wr) begin
      if (hit_bcr) bcr_q <= wb_bcr_val;
      if (hit_rcr) rcr_q <= wb_rcr_val;
    end
  end

  // refresh owed: software request or interrupted read; set wins over use
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ref_req_q <= 1'b0;
    end else if ((wb_wr & hit_ctrl & wb_sel_i[0] & wb_dat_i[0]) |
                 (abort_ce & rd_q)) begin
      ref_req_q <= 1'b1;
    end else if (start) begin
      ref_req_q <= 1'b0;
    end
  end

  // mode detection
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      full_sync_q <= 1'b0;
    end else if (~sync_sel) begin
      full_sync_q <= 1'b0;
    end else if (latch_ev) begin
      full_sync_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // burst engine
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= sbp_pkg::SBP_IDLE;
      rd_q <= 1'b0;
      cfg_rd_q <= 1'b0;
      baddr_q <= 23'h0;
      lat_cnt_q <= 3'h0;
      lat_used_q <= 4'h0;
      word_cnt_q <= 6'h0;
      mem_wait <= 1'b0;
    end else if (abort_ce) begin
      state_q <= sbp_pkg::SBP_IDLE;
      mem_wait <= 1'b0;
    end else if (start) begin
      state_q <= sbp_pkg::SBP_LAT;
      rd_q <= we_n;
      cfg_rd_q <= cfg_sel & we_n;
      baddr_q <= adr_s2_q;
      lat_cnt_q <= 3'(lat_sel - 4'h1);
      lat_used_q <= lat_sel;
      word_cnt_q <= 6'h0;
      mem_wait <= 1'b1;
    end else if (in_lat & kedge) begin
      lat_cnt_q <= lat_cnt_q - 3'h1;
      if (wait_early & (lat_cnt_q == 3'h2)) mem_wait <= 1'b0;
      if (lat_cnt_q == 3'h1) begin
        state_q <= sbp_pkg::SBP_XFER;
        mem_wait <= 1'b0;
      end
    end else if (xfer_step) begin
      word_cnt_q <= word_cnt_q + 6'h1;
      if (last_word) begin
        state_q <= sbp_pkg::SBP_IDLE;
        mem_wait <= 1'b1;
      end else begin
        baddr_q <= baddr_q + 23'h1;
      end
    end else if (idle) begin
      mem_wait <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // array and data pins
  // ----------------------------------------------------------------
  wire [`SBP_MEM_AW-1:0] widx = baddr_q[`SBP_MEM_AW-1:0];
  wire [`SBP_MEM_AW-1:0] ridx = (in_lat | last_word) ? widx : `SBP_MEM_AW'(widx + 1'b1);

  always_ff @(posedge clk) begin
    if (xfer_step & ~rd_q) mem[widx] <= dq_s2_q;
    else if (async_wr & ~ctl_p_q[7]) mem[adr_p_q[`SBP_MEM_AW-1:0]] <= dq_p_q;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dq_o <= 16'h0;
      dq_oe <= 1'b0;
    end else begin
      if ((in_lat & kedge & (lat_cnt_q == 3'h1)) | xfer_step)
        dq_o <= cfg_rd_q ? cfg_rdval : mem[ridx];
      dq_oe <= in_xfer & rd_q & ~oe_n & ~ce_n & ~start;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // link clock edges seen during latency
  logic [3:0] kcnt_q;
  always_ff @(posedge clk) begin
    if (sys_rst | start) kcnt_q <= 4'h0;
    else if (kedge & in_lat) kcnt_q <= kcnt_q + 4'h1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_start_sync_only: assert property (start |-> sync_sel)
    else $error("burst started with synchronous mode off");
  a_full_sync_cause: assert property ($rose(full_sync_q)
                                      |-> $past(kedge & ~adv_n & ~ce_n))
    else $error("full synchronous mode entered without latching edge");
  a_wait_at_start: assert property (start & ~abort_ce |=> mem_wait)
    else $error("wait not asserted at burst start");
  a_latency_count: assert property ($rose(in_xfer) |-> kcnt_q == 4'(lat_used_q - 4'h1))
    else $error("first word not at programmed latency");
  a_write_fixed: assert property (start & ~we_n |=> lat_used_q == lat_fix)
    else $error("burst write not at fixed latency");
  a_refresh_stretch: assert property (start & we_n & ~lat_fixed & ref_req_q & ~cfg_prog
                                      |=> lat_used_q == lat_coll)
    else $error("variable latency not lengthened on refresh");
  a_fixed_exact: assert property (start & lat_fixed |=> lat_used_q == lat_fix)
    else $error("fixed latency not exact");
  a_burst_stop: assert property (xfer_step & last_word & ~abort_ce & ~start |=> idle)
    else $error("burst did not stop at its length");
  a_addr_step: assert property (xfer_step & ~last_word & ~abort_ce & ~start
                                |=> baddr_q == $past(baddr_q) + 23'h1)
    else $error("word address did not advance");
  a_ce_float: assert property (ce_n |=> ##1 !dq_oe)
    else $error("data pins driven with chip disabled");
  a_restart_float: assert property (start & in_xfer |=> !dq_oe)
    else $error("data pins driven after a new burst started");
  a_wait_low_xfer: assert property (in_xfer |-> !mem_wait)
    else $error("wait high while data moves");
  a_read_drive: assert property (dq_oe |-> rd_q)
    else $error("data pins driven during a write burst");
  a_variable_plain: assert property (start & we_n & ~lat_fixed & ~ref_req_q
                                     |=> lat_used_q == lat_var)
    else $error("variable latency changed with no refresh owed");
  a_word_limit: assert property (in_xfer & ~cont_burst |-> word_cnt_q < len_words)
    else $error("burst ran past its length");
  a_sync_off: assert property (~sync_sel |=> !full_sync_q)
    else $error("full synchronous mode kept with synchronous operation off");

  // ----------------------------------------------------------------
  // coverage
  // ----------------------------------------------------------------
  c_read_burst: cover property (start & we_n ##[1:200] $fell(in_xfer));
  c_write_burst: cover property (start & ~we_n ##[1:200] $fell(in_xfer));
  c_read_restart: cover property (in_xfer & start);
  c_refresh_read: cover property (start & we_n & ref_req_q & ~lat_fixed);
  c_config_read: cover property (start & cfg_sel & we_n);

endmodule

/* File: tb/sbp_host.sv */
// host model that drives the memory pins of the burst port
`timescale 1ns/1ps

module sbp_host (
  // system
  input wire logic clk,
  // pins to the device
  output logic clk_in,
  output logic chip_en_n,
  output logic addr_latch_n,
  output logic out_en_n,
  output logic write_en_n,
  output logic lower_byte_en_n,
  output logic upper_byte_en_n,
  output logic config_reg_sel,
  output logic [22:0] mem_addr,
  output logic [15:0] dq_i,
  // pins from the device
  input wire logic [15:0] dq_o,
  input wire logic dq_oe,
  input wire logic mem_wait
);
  logic [15:0] wq [0:39];
  logic [15:0] rq [0:39];
  logic wt [0:47];
  logic ob;

  // ----------------------------------------------------------------
  // pin release between frames
  // ----------------------------------------------------------------
  task automatic idle();
    chip_en_n <= 1'b1;
    addr_latch_n <= 1'b1;
    out_en_n <= 1'b1;
    write_en_n <= 1'b1;
    lower_byte_en_n <= 1'b1;
    upper_byte_en_n <= 1'b1;
    config_reg_sel <= 1'b0;
  endtask

  initial begin
    clk_in <= 1'b0;
    mem_addr <= 23'h0;
    dq_i <= 16'h0;
    idle();
  end

  task automatic half();
    repeat (10) @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // frames; data words move at edges lat .. lat+n-1
  // ----------------------------------------------------------------
  task automatic burst(input logic wr, input logic cfg, input logic [22:0] a,
                       input int lat, input int n);
    int k;
    @(posedge clk);
    mem_addr <= a;
    config_reg_sel <= cfg;
    write_en_n <= ~wr;
    out_en_n <= wr;
    lower_byte_en_n <= 1'b0;
    upper_byte_en_n <= 1'b0;
    chip_en_n <= 1'b0;
    addr_latch_n <= 1'b0;
    for (k = 0; k < lat + n || k == 0; k++) begin
      if (wr && k >= lat) dq_i <= wq[k - lat];
      else dq_i <= ~dq_i;
      repeat (k == 0 ? 2 : 10) @(posedge clk);
      clk_in <= 1'b1;
      wt[k] = mem_wait;
      if (k >= lat) rq[k - lat] = dq_oe ? dq_o : ~dq_o;
      if (k == lat) ob = dq_oe;
      half();
      clk_in <= 1'b0;
      addr_latch_n <= 1'b1;
      mem_addr <= ~a;
    end
    idle();
    half();
    half();
  endtask

  task automatic split_wr(input logic [22:0] a, input logic [15:0] d, input logic ub);
    @(posedge clk);
    mem_addr <= a;
    dq_i <= d;
    chip_en_n <= 1'b0;
    write_en_n <= 1'b0;
    lower_byte_en_n <= 1'b0;
    upper_byte_en_n <= ub;
    half();
    write_en_n <= 1'b1;
    half();
    idle();
    dq_i <= ~d;
    mem_addr <= ~a;
    half();
  endtask
endmodule

/* File: tb/sbp_port_test.sv */
// self-checking bench for the burst pseudo-static RAM port
`timescale 1ns/1ps

module sbp_port_test;
  logic clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, b8;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q, rnd;
  logic clk_in, chip_en_n, addr_latch_n, out_en_n, write_en_n, dq_oe, mem_wait;
  logic lower_byte_en_n, upper_byte_en_n, config_reg_sel;
  logic [22:0] mem_addr, a;
  logic [15:0] dq_i, dq_o, v, d0;
  logic [15:0] p [0:39];
  int error_cnt = 0, comparisons = 0, cyc = 0, i, k, code, lat, n, lc;

  sbp_port uut (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .clk_in(clk_in), .chip_en_n(chip_en_n),
    .addr_latch_n(addr_latch_n), .out_en_n(out_en_n), .write_en_n(write_en_n),
    .lower_byte_en_n(lower_byte_en_n), .upper_byte_en_n(upper_byte_en_n),
    .config_reg_sel(config_reg_sel), .mem_addr(mem_addr), .dq_i(dq_i), .dq_o(dq_o),
    .dq_oe(dq_oe), .mem_wait(mem_wait));
  sbp_host host (.clk(clk), .clk_in(clk_in), .chip_en_n(chip_en_n),
    .addr_latch_n(addr_latch_n), .out_en_n(out_en_n), .write_en_n(write_en_n),
    .lower_byte_en_n(lower_byte_en_n), .upper_byte_en_n(upper_byte_en_n),
    .config_reg_sel(config_reg_sel), .mem_addr(mem_addr), .dq_i(dq_i), .dq_o(dq_o),
    .dq_oe(dq_oe), .mem_wait(mem_wait));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // expectations and helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic int lat_of(input int c, input logic fx, input logic wr, input logic pe);
    int b;
    if (fx || wr) return (c >= 2 && c <= 6) ? c + 1 : 4;
    b = (c == 2) ? 3 : 4;
    return pe ? 2 * b - 1 : b;
  endfunction
  function automatic logic [15:0] bcr_of(input logic fx, input int c, input logic w,
                                         input int l);
    return {1'b0, fx, c[2:0], 2'b00, w, 5'h00, l[2:0]};
  endfunction
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_w(input logic [15:0] got, input logic [15:0] exp);
    chk({16'h0000, got}, {16'h0000, exp});
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic chk_wait(input int l, input logic w);
    chk_bit(host.wt[1], 1'b1);
    chk_bit(host.wt[l - 1 - w], 1'b1);
    chk_bit(host.wt[l - w], 1'b0);
  endtask
  task automatic fill(input int m);
    for (int j = 0; j < m; j++) begin
      rnd = xs(rnd);
      host.wq[j] = rnd[15:0];
    end
  endtask
  task automatic wbx(input logic we, input logic [7:0] adr, input logic [31:0] d);
    int t;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 40);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, wb_ack_o, 1'b1);
    end
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      error_cnt++;
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rnd = 32'h0000003e;
    sys_rst <= 1'b1;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    wb_adr_i <= 8'h00;
    wb_sel_i <= 4'h3;
    wb_dat_i <= 32'h0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    wbx(1'b0, 8'h00, 32'h0);
    chk(q, 32'h00009907);
    wbx(1'b0, 8'h10, 32'h0);
    chk(q, 32'h00005a31);
    wbx(1'b0, 8'h14, 32'h0);
    chk(q, 32'h0);
    $display("test reset finished");
    wbx(1'b1, 8'h00, {16'h0, bcr_of(1'b1, 3, 1'b0, 1)});
    rnd = xs(rnd);
    d0 = rnd[15:0];
    host.split_wr(23'h40, d0, 1'b0);
    host.split_wr(23'h40, ~d0, 1'b1);
    wbx(1'b0, 8'h08, 32'h0);
    chk({30'h0, q[1:0]}, 32'h00000002);
    host.burst(1'b0, 1'b0, 23'h40, 4, 4);
    chk_w(host.rq[0], d0);
    wbx(1'b0, 8'h08, 32'h0);
    chk_bit(q[0], 1'b1);
    host.burst(1'b0, 1'b1, 23'h040000, 4, 1);
    chk_w(host.rq[0], 16'h5a31);
    $display("test split finished");
    for (i = 0; i < 5; i++) begin
      code = 2 + i;
      b8 = i[0];
      lc = 1 + i % 4;
      n = 4 << (lc - 1);
      lat = lat_of(code, 1'b1, 1'b0, 1'b0);
      v = bcr_of(1'b1, code, b8, lc);
      if (b8) host.burst(1'b1, 1'b1, {5'h02, 2'h0, v}, 1, 0);
      else wbx(1'b1, 8'h00, {16'h0, v});
      wbx(1'b0, 8'h00, 32'h0);
      chk(q, {16'h0, v});
      host.burst(1'b0, 1'b1, {5'h02, 18'h0}, lat, 1);
      chk_w(host.rq[0], v);
      rnd = xs(rnd);
      a = {13'h0, rnd[2:0], 7'h00};
      fill(n);
      for (k = 0; k < n; k++) p[k] = host.wq[k];
      host.burst(1'b1, 1'b0, a + 23'(n), lat, n);
      chk_wait(lat, b8);
      fill(n + 2);
      host.burst(1'b1, 1'b0, a, lat, n + 2);
      host.burst(1'b0, 1'b0, a, lat, n);
      chk_wait(lat, b8);
      chk_bit(host.ob, 1'b1);
      for (k = 0; k < n; k++) chk_w(host.rq[k], host.wq[k]);
      host.burst(1'b0, 1'b0, a + 23'(n), lat, n);
      for (k = 0; k < n; k++) chk_w(host.rq[k], p[k]);
      $display("test fixed latency %0d finished", lat);
    end
    wbx(1'b1, 8'h00, {16'h0, bcr_of(1'b0, 5, 1'b0, 1)});
    lat = lat_of(5, 1'b0, 1'b1, 1'b0);
    fill(4);
    host.burst(1'b1, 1'b0, 23'h80, lat, 4);
    chk_wait(lat, 1'b0);
    lat = lat_of(5, 1'b0, 1'b0, 1'b0);
    host.burst(1'b0, 1'b0, 23'h80, lat, 4);
    chk_wait(lat, 1'b0);
    chk_w(host.rq[3], host.wq[3]);
    wbx(1'b1, 8'h0c, 32'h1);
    lat = lat_of(5, 1'b0, 1'b0, 1'b1);
    host.burst(1'b0, 1'b0, 23'h80, lat, 4);
    chk_wait(lat, 1'b0);
    chk_w(host.rq[0], host.wq[0]);
    host.burst(1'b0, 1'b0, 23'h80, 4, 1);
    chk_bit(dq_oe, 1'b0);
    wbx(1'b0, 8'h0c, 32'h0);
    chk_bit(q[0], 1'b1);
    host.burst(1'b0, 1'b0, 23'h80, lat, 4);
    chk_wait(lat, 1'b0);
    chk_w(host.rq[1], host.wq[1]);
    $display("test variable latency finished");
    summarize();
  end
endmodule
